// ==== core/sfcd_core.sv ====
/*
 Serial flash command decoder: framing, decode, protection, page buffer.
 Assumes an array engine that reports busy and takes one-cycle op starts.
*/
// Function
// (R1) Program or erase touching a protected region is dropped without effect.
// (R2) Block lock bits count for protection only while per_block_lock_select is one.
// (R3) All block lock bits are one after power up.
// (R4) Chip select falling starts a frame and the first eight bits form the opcode.
// (R5) The input line is sampled on rising serial clock, msb first.
// (R6) Address, dummy or data bytes may follow the opcode; chip select rising ends it.
// (R7) A read may end after any bit and the output then stops.
// (R8) Write, program and erase act only when the frame ends on a byte boundary.
// (R9) While busy, every opcode but status read is ignored; the link still answers ABh with the identifier while busy.
// (R10) 50h enables a volatile status write, 06h sets and 04h clears write enable.
// (R11) ABh leaves power down and after three dummy bytes repeats the identifier.
// (R12) 75h requests a suspend of program or erase.
// (R13) 7Ah requests a resume of a suspended program or erase.
// (R14) A page program takes 1 to 256 bytes and wraps within its page.
// (R15) Status and identifier reads repeat their byte until chip select rises.
// (R16) Device reset happens only when 99h directly follows 66h.
// (R17) Three address bytes form a 24-bit address, high byte first.
`timescale 1ns/100ps
module sfcd_core import sfcd_pkg::*; #(
	parameter logic [7:0] DEV_ID = 8'h5A, // Arbitrary value
	parameter int NUM_BLOCKS = 128
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	input wire logic per_block_lock_select,
	input wire logic op_busy,
	output logic op_start,
	output sfcd_op_t op_kind,
	output logic [23:0] op_addr,
	output logic [8:0] op_len,
	output logic [7:0] status_wr_data,
	input wire logic [7:0] buf_rd_addr,
	output logic [7:0] buf_rd_data,
	output logic write_enabled,
	output logic power_down,
	output logic suspend_req,
	output logic resume_req,
	output logic dev_reset
);
	localparam int BLK_BITS = $clog2(NUM_BLOCKS);

	sfcd_link_if lk ();

	logic [2:0] sa_ff;
	logic [2:0] sb_ff;
	logic [2:0] sc_ff;
	logic [2:0] hold_ff;
	logic [2:0] agree;
	logic byte_ev;
	logic cs_fall;
	logic cs_rise;
	sfcd_state_t st_ff;
	logic [9:0] nbyte_ff;
	logic [7:0] opc_ff;
	logic [23:0] addr_ff;
	logic [7:0] sdata_ff;
	logic [7:0] pofs_ff;
	logic [8:0] pcnt_ff;
	logic [7:0] widx;
	logic [7:0] pgm_buf [0:255];
	logic [7:0] rd_ff;
	logic [NUM_BLOCKS-1:0] lock_ff;
	logic wel_ff;
	logic vsr_ff;
	logic pd_ff;
	logic arm_ff;
	logic [7:0] stat_ff;
	logic op_start_ff;
	sfcd_op_t op_kind_ff;
	logic [23:0] op_addr_ff;
	logic [8:0] op_len_ff;
	logic [7:0] swr_ff;
	logic sus_ff;
	logic res_ff;
	logic drst_ff;
	sfcd_op_t kind;
	logic allowed;
	logic go;
	logic prot;
	logic [9:0] need;
	logic launch;
	logic [BLK_BITS-1:0] blk;

	// ----------------------------------------
	// Decode helper
	// ----------------------------------------
	function automatic sfcd_op_t op_of(input logic [7:0] opc);
		case (opc)
			OPC_PROG: op_of = OP_PROG;
			OPC_ERASE4K: op_of = OP_E4K;
			OPC_ERASE32K: op_of = OP_E32K;
			OPC_ERASE64K: op_of = OP_E64K;
			OPC_CHIP_A, OPC_CHIP_B: op_of = OP_CHIP;
			OPC_STAT_WR: op_of = OP_STAT_WR;
			default: op_of = OP_NONE;
		endcase
	endfunction : op_of

	// ----------------------------------------
	// Link side
	// ----------------------------------------
	sfcd_link #(.DEV_ID(DEV_ID)) u_link (
		.sys_rst(sys_rst),
		.spi_clk(spi_clk),
		.cs_n(cs_n),
		.serial_in(serial_in),
		.serial_out(serial_out),
		.serial_out_en(serial_out_en),
		.lk(lk)
	);

	// Three-stage synchronisers, change counts when stages two and three agree
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			sa_ff <= SYNC_RST;
			sb_ff <= SYNC_RST;
			sc_ff <= SYNC_RST;
			hold_ff <= SYNC_RST;
		end else begin
			sa_ff <= {lk.rx_part, lk.rx_tog, cs_n};
			sb_ff <= sa_ff;
			sc_ff <= sb_ff;
			hold_ff <= (agree & sc_ff) | (~agree & hold_ff);
		end
	end

	assign agree = ~(sb_ff ^ sc_ff);
	assign byte_ev = agree[1] && (sc_ff[1] != hold_ff[1]);
	assign cs_fall = agree[0] && !sc_ff[0] && hold_ff[0]; // R4
	assign cs_rise = agree[0] && sc_ff[0] && !hold_ff[0]; // R6

	// Status byte offered to the link for reads
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stat_ff <= 8'h00;
		end else begin
			stat_ff <= 8'h00;
			stat_ff[ST_BUSY] <= op_busy;
			stat_ff[ST_WEL] <= wel_ff;
		end
	end

	assign lk.stat = stat_ff;

	// ----------------------------------------
	// Frame sequencing
	// ----------------------------------------
	// Done state gives a late byte one cycle to land
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff <= S_IDLE;
		end else begin
			case (st_ff)
				S_IDLE: if (cs_fall) st_ff <= S_FRAME;
				S_FRAME: if (cs_rise) st_ff <= S_DONE; // R6
				S_DONE: st_ff <= S_IDLE;
				default: st_ff <= S_IDLE;
			endcase
		end
	end

	// Opcode, address and data byte collection
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			nbyte_ff <= 10'h000;
			opc_ff <= 8'h00;
			addr_ff <= 24'h00_0000;
			sdata_ff <= 8'h00;
			pofs_ff <= 8'h00;
			pcnt_ff <= 9'h000;
		end else if (cs_fall) begin
			nbyte_ff <= 10'h000;
			pofs_ff <= 8'h00;
			pcnt_ff <= 9'h000;
		end else if (byte_ev && st_ff == S_FRAME) begin
			if (nbyte_ff != NBYTE_MAX)
				nbyte_ff <= 10'(nbyte_ff + 10'h001);
			if (nbyte_ff == 10'h000) begin
				opc_ff <= lk.rx_byte; // R4
			end else if (nbyte_ff <= ADDR_BYTES) begin
				addr_ff <= {addr_ff[15:0], lk.rx_byte}; // R17
			end else if (opc_ff == OPC_PROG) begin
				pofs_ff <= 8'(pofs_ff + 8'h01); // R14
				if (pcnt_ff != PAGE_BYTES)
					pcnt_ff <= 9'(pcnt_ff + 9'h001); // R14
			end
			if (nbyte_ff == LEN_ONE)
				sdata_ff <= lk.rx_byte;
		end
	end

	// Page buffer, index wraps inside the page
	assign widx = 8'(addr_ff[7:0] + pofs_ff); // R14

	always_ff @(posedge sys_clk) begin
		if (byte_ev && st_ff == S_FRAME && nbyte_ff > ADDR_BYTES && opc_ff == OPC_PROG)
			pgm_buf[widx] <= lk.rx_byte;
		rd_ff <= pgm_buf[buf_rd_addr];
	end

	// ----------------------------------------
	// Decision at frame end
	// ----------------------------------------
	assign blk = addr_ff[BLK_LSB +: BLK_BITS];

	always_comb begin
		kind = op_of(opc_ff);
		allowed = op_busy ? (opc_ff == OPC_STAT_RD) : (!pd_ff || opc_ff == OPC_WAKE_ID); // R9
		go = (st_ff == S_DONE) && !hold_ff[2] && (nbyte_ff != 10'h000) && allowed; // R8
		prot = per_block_lock_select && ((kind == OP_CHIP) ? (|lock_ff) : lock_ff[blk]); // R2
		case (kind)
			OP_PROG: need = LEN_PROG;
			OP_STAT_WR: need = LEN_STAT_WR;
			OP_CHIP: need = LEN_ONE;
			default: need = LEN_ADDR;
		endcase
		launch = go && (kind != OP_NONE) && (nbyte_ff >= need)
			&& (wel_ff || (kind == OP_STAT_WR && vsr_ff))
			&& !(prot && kind != OP_STAT_WR); // R1
	end

	// Latches, modes and one-cycle requests
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wel_ff <= 1'b0;
			vsr_ff <= 1'b0;
			pd_ff <= 1'b0;
			arm_ff <= 1'b0;
			sus_ff <= 1'b0;
			res_ff <= 1'b0;
			drst_ff <= 1'b0;
		end else begin
			sus_ff <= 1'b0;
			res_ff <= 1'b0;
			drst_ff <= 1'b0;
			if (go) begin
				arm_ff <= (opc_ff == OPC_RST_EN); // R16
				case (opc_ff)
					OPC_WREN: wel_ff <= 1'b1; // R10
					OPC_WRDIS: wel_ff <= 1'b0; // R10
					OPC_STAT_WEN: vsr_ff <= 1'b1; // R10
					OPC_WAKE_ID: pd_ff <= 1'b0; // R11
					OPC_SLEEP: pd_ff <= 1'b1;
					OPC_SUSPEND: sus_ff <= 1'b1; // R12
					OPC_RESUME: res_ff <= 1'b1; // R13
					OPC_RST: begin
						if (arm_ff) begin
							drst_ff <= 1'b1; // R16
							wel_ff <= 1'b0;
							vsr_ff <= 1'b0;
						end
					end
					default: begin
					end
				endcase
				if (launch) begin
					wel_ff <= 1'b0;
					vsr_ff <= 1'b0;
				end
			end
		end
	end

	// Operation start towards the array engine
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			op_start_ff <= 1'b0;
			op_kind_ff <= OP_NONE;
			op_addr_ff <= 24'h00_0000;
			op_len_ff <= 9'h000;
			swr_ff <= 8'h00;
		end else begin
			op_start_ff <= launch; // R1
			if (launch) begin
				op_kind_ff <= kind;
				op_addr_ff <= addr_ff;
				op_len_ff <= pcnt_ff;
				swr_ff <= sdata_ff;
			end
		end
	end

	// Block locks, all set at power up and on device reset
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_ff <= '1; // R3
		end else if (go && opc_ff == OPC_RST && arm_ff) begin
			lock_ff <= '1; // R3
		end else if (go && wel_ff) begin
			case (opc_ff)
				OPC_LOCK_ALL: lock_ff <= '1;
				OPC_UNLOCK_ALL: lock_ff <= '0;
				OPC_LOCK_ONE: if (nbyte_ff >= LEN_ADDR) lock_ff[blk] <= 1'b1;
				OPC_UNLOCK_ONE: if (nbyte_ff >= LEN_ADDR) lock_ff[blk] <= 1'b0;
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign op_start = op_start_ff;
	assign op_kind = op_kind_ff;
	assign op_addr = op_addr_ff;
	assign op_len = op_len_ff;
	assign status_wr_data = swr_ff;
	assign buf_rd_data = rd_ff;
	assign write_enabled = wel_ff;
	assign power_down = pd_ff;
	assign suspend_req = sus_ff;
	assign resume_req = res_ff;
	assign dev_reset = drst_ff;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_lock_power_up: assert property (@(posedge sys_clk) disable iff (sys_rst) // R3
		$past(sys_rst) |-> (&lock_ff))
		else $error("lock bits not all set after reset");
	chk_protect_drop: assert property (@(posedge sys_clk) disable iff (sys_rst) // R1
		(op_start_ff && op_kind_ff != OP_STAT_WR && op_kind_ff != OP_CHIP && per_block_lock_select)
		|-> !lock_ff[op_addr_ff[BLK_LSB +: BLK_BITS]])
		else $error("operation started on locked block");
	chk_lock_select: assert property (@(posedge sys_clk) disable iff (sys_rst) // R2
		(go && kind == OP_E4K && wel_ff && nbyte_ff >= LEN_ADDR && !per_block_lock_select)
		|=> op_start_ff)
		else $error("locks applied with block locking off");
	chk_mid_byte: assert property (@(posedge sys_clk) disable iff (sys_rst) // R8
		(st_ff == S_DONE && hold_ff[2]) |=> !op_start_ff && $stable(wel_ff))
		else $error("partial byte frame took effect");
	chk_busy_ignore: assert property (@(posedge sys_clk) disable iff (sys_rst) // R9
		(st_ff == S_DONE && op_busy) |=> !op_start_ff && !sus_ff && $stable(wel_ff))
		else $error("instruction taken while busy");
	chk_wel_cmds: assert property (@(posedge sys_clk) disable iff (sys_rst) // R10
		(go && opc_ff == OPC_WREN) |=> wel_ff ##1 (st_ff != S_DONE) [*2] ##0 wel_ff)
		else $error("write enable not set");
	chk_reset_arm: assert property (@(posedge sys_clk) disable iff (sys_rst) // R16
		$rose(drst_ff) |-> $past(arm_ff) && $past(opc_ff) == OPC_RST)
		else $error("reset without enable");
	chk_page_len: assert property (@(posedge sys_clk) disable iff (sys_rst) // R14
		(op_start_ff && op_kind_ff == OP_PROG) |-> (op_len_ff != 9'h000) && (op_len_ff <= PAGE_BYTES))
		else $error("page program length out of range");
	chk_out_stop: assert property (@(posedge sys_clk) disable iff (sys_rst) // R7
		cs_n |-> !serial_out_en && !serial_out)
		else $error("output driven with chip select high");
endmodule : sfcd_core

// ==== core/sfcd_link.sv ====
/*
 Link-clock shifter: frames bits into bytes and drives read answers.
 Assumes the serial clock idles between frames and chip select is a pin.
*/
`timescale 1ns/100ps
module sfcd_link import sfcd_pkg::*; #(
	parameter logic [7:0] DEV_ID = 8'h5A // Arbitrary value
) (
	input wire logic sys_rst,
	input wire logic spi_clk,
	input wire logic cs_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_en,
	sfcd_link_if.link lk
);
	logic run_ff;
	logic [2:0] bcnt_ff;
	logic [2:0] nbyt_ff;
	logic [7:0] sh_ff;
	logic [7:0] byte_ff;
	logic tog_ff;
	sfcd_sel_t sel_ff;
	logic [7:0] st1_ff;
	logic [7:0] st2_ff;
	logic [7:0] st3_ff;
	logic [7:0] sthold_ff;
	logic [7:0] tx_ff;
	logic oen_ff;
	logic byte_end;
	logic load;

	// ----------------------------------------
	// Input framing
	// ----------------------------------------
	// Frame marker, cleared while chip select is high
	always_ff @(posedge spi_clk or posedge sys_rst or posedge cs_n) begin
		if (sys_rst) begin
			run_ff <= 1'b0;
		end else if (cs_n) begin
			run_ff <= 1'b0;
		end else begin
			run_ff <= 1'b1; // R4
		end
	end

	assign byte_end = run_ff && (bcnt_ff == LAST_BIT);

	// Sample on rising edge, first bit is the msb
	always_ff @(posedge spi_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bcnt_ff <= 3'h0;
			nbyt_ff <= 3'h0;
			sh_ff <= 8'h00;
			byte_ff <= 8'h00;
			tog_ff <= 1'b0;
			sel_ff <= SEL_NONE;
		end else begin
			bcnt_ff <= run_ff ? 3'(bcnt_ff + 3'h1) : 3'h1; // R4
			sh_ff <= {sh_ff[6:0], serial_in}; // R5
			if (!run_ff) begin
				nbyt_ff <= 3'h0;
				sel_ff <= SEL_NONE;
			end else if (byte_end) begin
				byte_ff <= {sh_ff[6:0], serial_in}; // R5
				tog_ff <= ~tog_ff;
				if (nbyt_ff != NBYT_MAX)
					nbyt_ff <= 3'(nbyt_ff + 3'h1);
				if (nbyt_ff == 3'h0) begin
					// Opcode picks the read answer
					if ({sh_ff[6:0], serial_in} == OPC_STAT_RD)
						sel_ff <= SEL_STAT;
					else if ({sh_ff[6:0], serial_in} == OPC_WAKE_ID)
						sel_ff <= SEL_ID; // R11
				end
			end
		end
	end

	// Status byte crosses in through three stages, a bit counts once stages two and three agree
	always_ff @(posedge spi_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st1_ff <= 8'h00;
			st2_ff <= 8'h00;
			st3_ff <= 8'h00;
			sthold_ff <= 8'h00;
		end else begin
			st1_ff <= lk.stat;
			st2_ff <= st1_ff;
			st3_ff <= st2_ff;
			sthold_ff <= (~(st2_ff ^ st3_ff) & st3_ff) | ((st2_ff ^ st3_ff) & sthold_ff);
		end
	end

	// ----------------------------------------
	// Output shifting
	// ----------------------------------------
	assign load = run_ff && (bcnt_ff == 3'h0) && ((sel_ff == SEL_STAT && nbyt_ff != 3'h0)
		|| (sel_ff == SEL_ID && nbyt_ff >= ID_START));

	// Reload the answer byte at every byte boundary so it repeats
	always_ff @(negedge spi_clk or posedge sys_rst or posedge cs_n) begin
		if (sys_rst) begin
			tx_ff <= 8'h00;
			oen_ff <= 1'b0;
		end else if (cs_n) begin
			tx_ff <= 8'h00;
			oen_ff <= 1'b0; // R7
		end else if (load) begin
			tx_ff <= (sel_ff == SEL_STAT) ? sthold_ff : DEV_ID; // R15
			oen_ff <= 1'b1;
		end else begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	assign serial_out = tx_ff[7];
	assign serial_out_en = oen_ff && !cs_n; // R7
	assign lk.rx_byte = byte_ff;
	assign lk.rx_tog = tog_ff;
	assign lk.rx_part = bcnt_ff != 3'h0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_msb_first: assert property (@(posedge spi_clk) disable iff (sys_rst) // R5
		(!run_ff && !cs_n && serial_in) |-> ##8 lk.rx_byte[7])
		else $error("first bit of frame not in opcode msb");
	chk_id_delay: assert property (@(negedge spi_clk) disable iff (sys_rst) // R11
		($rose(oen_ff) && sel_ff == SEL_ID) |-> nbyt_ff == ID_START)
		else $error("identifier not after three dummy bytes");
endmodule : sfcd_link

// ==== core/sfcd_link_if.sv ====
/*
 Carrier between the link-clock shifter and the system-clock decoder.
 Assumes the decoder reads rx_byte only after rx_tog has crossed, and all other signals of each side through synchronisers.
*/
`timescale 1ns/100ps
interface sfcd_link_if;
	logic [7:0] rx_byte;
	logic rx_tog;
	logic rx_part;
	logic [7:0] stat;
	modport link (output rx_byte, output rx_tog, output rx_part, input stat);
	modport core (input rx_byte, input rx_tog, input rx_part, output stat);
endinterface : sfcd_link_if

// ==== core/sfcd_pkg.sv ====
/*
 Shared constants and types of the serial flash command decoder.
 Assumes a standard single-line serial link, mode 0 or 3.
*/
package sfcd_pkg;
	// ----------------------------------------
	// Opcodes
	// ----------------------------------------
	localparam logic [7:0] OPC_WREN = 8'h06;
	localparam logic [7:0] OPC_WRDIS = 8'h04;
	localparam logic [7:0] OPC_STAT_WEN = 8'h50;
	localparam logic [7:0] OPC_STAT_RD = 8'h05;
	localparam logic [7:0] OPC_STAT_WR = 8'h01;
	localparam logic [7:0] OPC_WAKE_ID = 8'hAB;
	localparam logic [7:0] OPC_SLEEP = 8'hB9;
	localparam logic [7:0] OPC_PROG = 8'h02;
	localparam logic [7:0] OPC_ERASE4K = 8'h20;
	localparam logic [7:0] OPC_ERASE32K = 8'h52;
	localparam logic [7:0] OPC_ERASE64K = 8'hD8;
	localparam logic [7:0] OPC_CHIP_A = 8'hC7;
	localparam logic [7:0] OPC_CHIP_B = 8'h60;
	localparam logic [7:0] OPC_LOCK_ALL = 8'h7E;
	localparam logic [7:0] OPC_UNLOCK_ALL = 8'h98;
	localparam logic [7:0] OPC_LOCK_ONE = 8'h36;
	localparam logic [7:0] OPC_UNLOCK_ONE = 8'h39;
	localparam logic [7:0] OPC_SUSPEND = 8'h75;
	localparam logic [7:0] OPC_RESUME = 8'h7A;
	localparam logic [7:0] OPC_RST_EN = 8'h66;
	localparam logic [7:0] OPC_RST = 8'h99;
	// ----------------------------------------
	// Framing counts and layouts
	// ----------------------------------------
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [2:0] ID_START = 3'h4;
	localparam logic [2:0] NBYT_MAX = 3'h7;
	localparam logic [9:0] ADDR_BYTES = 10'h003;
	localparam logic [9:0] LEN_ADDR = 10'h004;
	localparam logic [9:0] LEN_PROG = 10'h005;
	localparam logic [9:0] LEN_STAT_WR = 10'h002;
	localparam logic [9:0] LEN_ONE = 10'h001;
	localparam logic [9:0] NBYTE_MAX = 10'h3FF;
	localparam logic [8:0] PAGE_BYTES = 9'h100;
	localparam int BLK_LSB = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_WEL = 1;
	localparam logic [2:0] SYNC_RST = 3'h1;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {SEL_NONE = 3'b001, SEL_STAT = 3'b010, SEL_ID = 3'b100} sfcd_sel_t;
	typedef enum logic [2:0] {S_IDLE = 3'b001, S_FRAME = 3'b010, S_DONE = 3'b100} sfcd_state_t;
	typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_E4K, OP_E32K, OP_E64K, OP_CHIP, OP_STAT_WR} sfcd_op_t;
endpackage : sfcd_pkg

// ==== sim/sfcd_core_tb.sv ====
/*
 Self-checking testbench of the serial flash command decoder.
 Assumes the host model drives the link and the bench plays the array engine.
*/
`timescale 1ns/100ps
module sfcd_core_tb import sfcd_pkg::*;;
	localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary identifier value
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b0;
	logic spi_clk, cs_n, serial_in, serial_out, serial_out_en;
	logic per_block_lock_select = 1'b0;
	logic op_busy = 1'b0;
	logic op_start, write_enabled, power_down, suspend_req, resume_req, dev_reset;
	sfcd_op_t op_kind;
	logic [23:0] op_addr;
	logic [8:0] op_len;
	logic [7:0] status_wr_data, buf_rd_data;
	logic [7:0] buf_rd_addr = 8'h00;
	int error_cnt = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_susp = 0;
	int n_res = 0;
	int n_rst = 0;

	// System clock
	always #5 sys_clk = ~sys_clk;

	sfcd_core #(.DEV_ID(ID_VAL)) i_sfcd_core (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
		.cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
		.per_block_lock_select(per_block_lock_select), .op_busy(op_busy), .op_start(op_start),
		.op_kind(op_kind), .op_addr(op_addr), .op_len(op_len), .status_wr_data(status_wr_data),
		.buf_rd_addr(buf_rd_addr), .buf_rd_data(buf_rd_data), .write_enabled(write_enabled),
		.power_down(power_down), .suspend_req(suspend_req), .resume_req(resume_req), .dev_reset(dev_reset));

	sfcd_host_model i_sfcd_host_model (.spi_clk(spi_clk), .cs_n(cs_n), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_en(serial_out_en));

	// Counts the one-cycle pulses
	always @(posedge sys_clk) begin
		if (op_start === 1'b1) n_start <= n_start + 1;
		if (suspend_req === 1'b1) n_susp <= n_susp + 1;
		if (resume_req === 1'b1) n_res <= n_res + 1;
		if (dev_reset === 1'b1) n_rst <= n_rst + 1;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Sends one frame, then lets the result cross into the system domain
	task automatic frame(input int nbits);
		i_sfcd_host_model.send(nbits);
		repeat (20) @(posedge sys_clk);
		#1;
	endtask : frame

	task automatic cmd1(input logic [7:0] opc);
		i_sfcd_host_model.tx_buf[0] = opc;
		frame(8);
	endtask : cmd1

	task automatic load_addr(input logic [7:0] opc, input logic [23:0] a);
		i_sfcd_host_model.tx_buf[0] = opc;
		i_sfcd_host_model.tx_buf[1] = a[23:16];
		i_sfcd_host_model.tx_buf[2] = a[15:8];
		i_sfcd_host_model.tx_buf[3] = a[7:0];
	endtask : load_addr

	task automatic read_status(input logic [7:0] exp);
		i_sfcd_host_model.tx_buf[0] = OPC_STAT_RD;
		frame(32);
		check("status", i_sfcd_host_model.rx_byte, exp);
	endtask : read_status

	task automatic check_buf(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk) buf_rd_addr <= a;
		repeat (2) @(posedge sys_clk);
		#1;
		check("page byte", buf_rd_data, exp);
	endtask : check_buf

	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_enables();
		check("reset kind", op_kind, OP_NONE);
		check("reset wel", write_enabled, 1'b0);
		cmd1(OPC_WREN);
		check("wel set", write_enabled, 1'b1);
		read_status(8'h02);
		cmd1(OPC_WRDIS);
		check("wel clear", write_enabled, 1'b0);
		i_sfcd_host_model.tx_buf[0] = OPC_STAT_RD;
		frame(13);
		check("out released", serial_out_en, 1'b0);
		cmd1(OPC_STAT_WEN);
		i_sfcd_host_model.tx_buf[0] = OPC_STAT_WR;
		i_sfcd_host_model.tx_buf[1] = 8'hA5;
		frame(16);
		check("stat wr start", n_start, 1);
		check("stat wr kind", op_kind, OP_STAT_WR);
		check("stat wr data", status_wr_data, 8'hA5);
	endtask : t_enables

	task automatic t_program();
		cmd1(OPC_WREN);
		load_addr(OPC_PROG, 24'h12_34F0);
		for (int k = 0; k < 258; k++) i_sfcd_host_model.tx_buf[4 + k] = (k < 256) ? (8'(k) ^ 8'hA5) : 8'h3C;
		frame(262 * 8);
		check("prog start", n_start, 2);
		check("prog kind", op_kind, OP_PROG);
		check("prog addr", op_addr, 24'h12_34F0);
		check("prog len", op_len, 9'h100);
		check("prog wel", write_enabled, 1'b0);
		check_buf(8'hF0, 8'h3C);
		check_buf(8'hF1, 8'h3C);
		check_buf(8'hF2, 8'hA7);
		check_buf(8'h00, 8'hB5);
	endtask : t_program

	task automatic t_protect();
		cmd1(OPC_WREN);
		load_addr(OPC_ERASE4K, 24'h05_0000);
		frame(32);
		check("free erase", n_start, 3);
		@(posedge sys_clk) per_block_lock_select <= 1'b1;
		cmd1(OPC_WREN);
		load_addr(OPC_ERASE4K, 24'h05_0000);
		frame(32);
		check("locked erase", n_start, 3);
		cmd1(OPC_UNLOCK_ALL);
		load_addr(OPC_LOCK_ONE, 24'h05_0000);
		frame(32);
		load_addr(OPC_ERASE64K, 24'h05_0000);
		frame(32);
		check("block lock", n_start, 3);
		load_addr(OPC_ERASE32K, 24'h06_0000);
		frame(32);
		check("open erase", n_start, 4);
		check("erase kind", op_kind, OP_E32K);
		cmd1(OPC_WREN);
		cmd1(OPC_CHIP_A);
		check("chip locked", n_start, 4);
		load_addr(OPC_ERASE4K, 24'h06_0000);
		frame(36);
		check("partial erase", n_start, 4);
		check("partial wel", write_enabled, 1'b1);
	endtask : t_protect

	task automatic t_busy();
		@(posedge sys_clk) op_busy <= 1'b1;
		cmd1(OPC_WRDIS);
		check("busy wel", write_enabled, 1'b1);
		read_status(8'h03);
		@(posedge sys_clk) op_busy <= 1'b0;
		cmd1(OPC_WRDIS);
		check("idle wel", write_enabled, 1'b0);
	endtask : t_busy

	task automatic t_misc();
		cmd1(OPC_SLEEP);
		check("asleep", power_down, 1'b1);
		cmd1(OPC_WREN);
		check("asleep wel", write_enabled, 1'b0);
		i_sfcd_host_model.tx_buf[0] = OPC_WAKE_ID;
		for (int k = 1; k < 4; k++) i_sfcd_host_model.tx_buf[k] = 8'h00;
		frame(48);
		check("ident", i_sfcd_host_model.rx_byte, ID_VAL);
		check("awake", power_down, 1'b0);
		cmd1(OPC_SUSPEND);
		check("suspend", n_susp, 1);
		cmd1(OPC_RESUME);
		check("resume", n_res, 1);
		cmd1(OPC_RST);
		check("lone reset", n_rst, 0);
		cmd1(OPC_WREN);
		cmd1(OPC_RST_EN);
		cmd1(OPC_RST);
		check("armed reset", n_rst, 1);
		check("wel after reset", write_enabled, 1'b0);
	endtask : t_misc

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		sys_rst <= 1'b1; // Rising edge clears the link flops, which see no clock yet
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge sys_clk);
		t_enables();
		t_program();
		t_protect();
		t_busy();
		t_misc();
		conclude();
	end

	// Cuts a hang short
	initial begin
		#900_000;
		error_cnt++;
		conclude();
	end
endmodule : sfcd_core_tb

// ==== sim/sfcd_host_model.sv ====
/*
 Host-side model of the serial link: frames opcode and operand bytes.
 Assumes the testbench fills tx_buf before each call of send.
*/
`timescale 1ns/100ps
module sfcd_host_model (
	output logic spi_clk,
	output logic cs_n,
	output logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_en
);
	logic [7:0] tx_buf [0:263];
	logic [7:0] rx_byte;

	// Idle bus: clock still, chip select high
	initial begin
		spi_clk = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
		rx_byte = 8'h00;
	end

	// ----------------------------------------
	// Frame
	// ----------------------------------------
	// Clocks nbits of tx_buf out and shifts in the answer on rising edges
	task automatic send(input int nbits);
		#3.7;
		cs_n = 1'b0;
		for (int k = 0; k < nbits; k++) begin
			#20;
			serial_in = tx_buf[k / 8][7 - k % 8];
			#20;
			spi_clk = 1'b1;
			if (serial_out_en === 1'b1) begin
				rx_byte = {rx_byte[6:0], serial_out};
			end
			#40;
			spi_clk = 1'b0;
		end
		#60;
		cs_n = 1'b1;
		serial_in = ~serial_in; // Released line must not look held
		#200;
	endtask : send
endmodule : sfcd_host_model
